// >>> hdl/plbf_block.sv
// One logic block with its routing matrix, allocator, macrocells and pin cells.
// Assumes pins are asynchronous and configuration stays static in operation.
//
// Operation
// - 64 terms, allocator, 8+8 macrocells, 8 pins
// - Routing gives 26 inputs per block
// - Sources: 64 pins, 2 inputs, 4 clocks
// - Four extra terms: two enables, clear, set
// - Clear and set hit all block storage
// - Block returns 16 macrocell, 8 pin feedbacks
// - Buried feedback only to own or sibling
// - Pin macrocell feedback reaches every block
// - At most 16 terms per macrocell
// - Macrocell k uses clusters k-1 to k+2
// - Register, latch or combinational, with inversion
// - Feedback driven in every configuration
// - Register may be D or T type
// - Each storage picks one of four clocks
// - Registers capture on rising clock edge
// - Latch transparent low, holds while high
// - Clear and set act without clock
// - Buried cells internal, may register pin input
// - Driver on, off, or either enable term
// - Pin usable as input via feedback
`timescale 1ns/1ns
`default_nettype none
module plbf_block
    import plbf_pkg::*;
#(
    parameter int BLOCK_ID = 0
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [PLBF_IO_PINS-1:0] IO_PIN_I,
    input wire logic [PLBF_DED_IN-1:0] DED_IN,
    input wire logic [PLBF_CLK_PINS-1:0] CLK_PIN,
    input wire logic [PLBF_BLOCKS-1:0][PLBF_PIN_CELLS-1:0] BLK_OUT_FB,
    input wire logic [PLBF_PIN_CELLS-1:0] SIB_BUR_FB,
    input wire logic [PLBF_BLK_IN-1:0][PLBF_SRC_W-1:0] CFG_ROUTE,
    input wire logic [PLBF_ALL_TERMS-1:0][PLBF_BLK_IN-1:0] CFG_AND_T,
    input wire logic [PLBF_ALL_TERMS-1:0][PLBF_BLK_IN-1:0] CFG_AND_C,
    input wire logic [PLBF_CLUSTERS-1:0] CFG_CL_EN,
    input wire logic [PLBF_CLUSTERS-1:0][1:0] CFG_CL_DEST,
    input wire logic [PLBF_MCELLS-1:0][2:0] CFG_MODE,
    input wire logic [PLBF_MCELLS-1:0] CFG_TTYPE,
    input wire logic [PLBF_MCELLS-1:0] CFG_INV,
    input wire logic [PLBF_MCELLS-1:0][1:0] CFG_CLK_SEL,
    input wire logic [PLBF_PIN_CELLS-1:0] CFG_INREG,
    input wire logic [PLBF_PIN_CELLS-1:0][3:0] CFG_OE,
    output logic [PLBF_PIN_CELLS-1:0] PIN_O,
    output logic [PLBF_PIN_CELLS-1:0] PIN_OE_N,
    output logic [PLBF_MCELLS-1:0] MC_FB,
    output logic [PLBF_PIN_CELLS-1:0] PIN_FB
);
    localparam int SYNC_W = PLBF_IO_PINS + PLBF_DED_IN + PLBF_CLK_PINS;
    localparam int PIN_BASE = BLOCK_ID * PLBF_PIN_CELLS;

    // =====================================================================
    // Elaboration checks
    if (BLOCK_ID < 0 || BLOCK_ID >= PLBF_BLOCKS)
    begin : g_bad_id
        $error("BLOCK_ID out of range");
    end
    if (PLBF_CLUSTERS * PLBF_CL_SIZE != PLBF_TERMS)
    begin : g_bad_cl
        $error("Cluster layout does not cover the term array");
    end
    // Special terms sit right after the logic terms, in a fixed order
    if (PLBF_ALL_TERMS != PLBF_TERMS + PLBF_SPECIAL || PLBF_PT_OE0 != PLBF_TERMS
        || PLBF_PT_OE1 != PLBF_PT_OE0 + 1 || PLBF_PT_CLR != PLBF_PT_OE1 + 1
        || PLBF_PT_SET != PLBF_ALL_TERMS - 1)
    begin : g_bad_pt
        $error("Special terms do not follow the logic terms");
    end
    // Even cells sit on pins, odd cells are buried
    if (PLBF_MCELLS != 2 * PLBF_PIN_CELLS)
    begin : g_bad_cells
        $error("Macrocells must pair one pin cell with one buried cell");
    end
    // Every block owns one slice of the pins; siblings come in pairs
    if (PLBF_IO_PINS != PLBF_BLOCKS * PLBF_PIN_CELLS || PLBF_BLOCKS % 2 != 0)
    begin : g_bad_pins
        $error("Pins or sibling pairs do not match the block count");
    end
    // Clock select width must reach every clock pin exactly
    if (PLBF_CLK_PINS != 2 ** $bits(CFG_CLK_SEL[0]))
    begin : g_bad_clk
        $error("Clock select width does not match the clock pins");
    end
    // Source map is contiguous, so no source hides behind another
    if (PLBF_SRC_DED != PLBF_SRC_IO + PLBF_IO_PINS || PLBF_SRC_CLK != PLBF_SRC_DED + PLBF_DED_IN
        || PLBF_SRC_OWN != PLBF_SRC_CLK + PLBF_CLK_PINS || PLBF_SRC_SIB != PLBF_SRC_OWN + PLBF_MCELLS
        || PLBF_SRC_BLK != PLBF_SRC_SIB + PLBF_PIN_CELLS
        || PLBF_SRC_NUM != PLBF_SRC_BLK + PLBF_BLOCKS * PLBF_PIN_CELLS)
    begin : g_bad_src
        $error("Routing source map has a gap or an overlap");
    end
    if (PLBF_SRC_NUM > 2 ** PLBF_SRC_W)
    begin : g_bad_sel
        $error("Route selector too narrow for the source count");
    end

    // Cluster index and destination code to macrocell index, -1 when clipped
    function automatic int dest_mc(input int c, input logic [1:0] d);
        int k;
        k = c + 1 - int'(d);
        if (k < 0 || k >= PLBF_MCELLS)
        begin
            k = -1;
        end
        return k;
    endfunction

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [PLBF_CLK_PINS-1:0] clk_prev_q;
    logic [PLBF_CLK_PINS-1:0] clk_rise;
    logic [PLBF_IO_PINS-1:0] io_s;
    logic [PLBF_DED_IN-1:0] ded_s;
    logic [PLBF_CLK_PINS-1:0] clk_s;
    logic [PLBF_SRC_NUM-1:0] src;
    logic [PLBF_BLK_IN-1:0] blk_in;
    logic [PLBF_ALL_TERMS-1:0] term;
    logic [PLBF_CLUSTERS-1:0] cl_or;
    logic [PLBF_MCELLS-1:0] sum;
    logic [PLBF_MCELLS-1:0] fb;
    logic [PLBF_MCELLS-1:0] mc_fb_q;
    logic [PLBF_PIN_CELLS-1:0] pin_o_q;
    logic [PLBF_PIN_CELLS-1:0] pin_oe_n_q;
    logic [PLBF_PIN_CELLS-1:0] pin_fb_q;

    // =====================================================================
    // Pin synchronisers
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {CLK_PIN, DED_IN, IO_PIN_I};
            sync2_q <= sync1_q;
        end
    end

    assign io_s = sync2_q[PLBF_IO_PINS-1:0];
    assign ded_s = sync2_q[PLBF_IO_PINS+PLBF_DED_IN-1:PLBF_IO_PINS];
    assign clk_s = sync2_q[SYNC_W-1:PLBF_IO_PINS+PLBF_DED_IN];

    // =====================================================================
    // Clock pin edge detection
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            clk_prev_q <= '0;
        end
        else
        begin
            clk_prev_q <= clk_s;
        end
    end

    assign clk_rise = clk_s & ~clk_prev_q; // Rising edge only

    // =====================================================================
    // Routing sources
    always_comb
    begin
        src = '0;
        src[PLBF_SRC_IO +: PLBF_IO_PINS] = io_s;
        src[PLBF_SRC_DED +: PLBF_DED_IN] = ded_s;
        src[PLBF_SRC_CLK +: PLBF_CLK_PINS] = clk_s; // Clocks as data
        src[PLBF_SRC_OWN +: PLBF_MCELLS] = mc_fb_q;
        src[PLBF_SRC_SIB +: PLBF_PIN_CELLS] = SIB_BUR_FB; // Sibling buried only
        for (int b = 0; b < PLBF_BLOCKS; b++)
        begin
            src[PLBF_SRC_BLK + b*PLBF_PIN_CELLS +: PLBF_PIN_CELLS] = BLK_OUT_FB[b];
        end
        for (int j = 0; j < PLBF_PIN_CELLS; j++)
        begin
            src[PLBF_SRC_BLK + BLOCK_ID*PLBF_PIN_CELLS + j] = mc_fb_q[2*j];
        end
    end

    // =====================================================================
    // Routing selectors, out-of-range selection reads low
    always_comb
    begin
        for (int i = 0; i < PLBF_BLK_IN; i++)
        begin
            if (int'(CFG_ROUTE[i]) < PLBF_SRC_NUM)
            begin
                blk_in[i] = src[CFG_ROUTE[i]];
            end
            else
            begin
                blk_in[i] = 1'h0;
            end
        end
    end

    // =====================================================================
    // Product term array, logic terms plus four special terms
    genvar gt;
    generate
        for (gt = 0; gt < PLBF_ALL_TERMS; gt++)
        begin : g_term
            assign term[gt] = &(~CFG_AND_T[gt] | blk_in) & &(~CFG_AND_C[gt] | ~blk_in);
        end
    endgenerate

    // =====================================================================
    // Logic allocator
    always_comb
    begin
        for (int c = 0; c < PLBF_CLUSTERS; c++)
        begin
            cl_or[c] = |term[c*PLBF_CL_SIZE +: PLBF_CL_SIZE];
        end
        sum = '0;
        for (int c = 0; c < PLBF_CLUSTERS; c++)
        begin
            for (int k = 0; k < PLBF_MCELLS; k++)
            begin
                if (CFG_CL_EN[c] && dest_mc(c, CFG_CL_DEST[c]) == k)
                begin
                    sum[k] = sum[k] | cl_or[c]; // Four clusters max, 16 terms
                end
            end
        end
    end

    // =====================================================================
    // Macrocells, even index on a pin, odd index buried
    genvar gm;
    generate
        for (gm = 0; gm < PLBF_MCELLS; gm++)
        begin : g_mc
            plbf_mcell u_mc (
                .clk(SYS_CLK),
                .rst(RST),
                .sum(sum[gm]),
                .pin_d(io_s[PIN_BASE + gm/2]),
                .inreg((gm % 2 == 1) ? CFG_INREG[gm/2] : 1'h0),
                .mode(CFG_MODE[gm]),
                .ttype(CFG_TTYPE[gm]),
                .inv(CFG_INV[gm]),
                .clk_rise(clk_rise[CFG_CLK_SEL[gm]]),
                .gate_lvl(clk_s[CFG_CLK_SEL[gm]]),
                .clr(term[PLBF_PT_CLR]),
                .set(term[PLBF_PT_SET]),
                .fb(fb[gm])
            );
        end
    endgenerate

    // =====================================================================
    // Registered feedback back into the routing
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            mc_fb_q <= '0;
            pin_fb_q <= '0;
        end
        else
        begin
            mc_fb_q <= fb;
            pin_fb_q <= io_s[PIN_BASE +: PLBF_PIN_CELLS];
        end
    end

    // =====================================================================
    // Pin cells, three-state driver control
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            pin_o_q <= '0;
            pin_oe_n_q <= {PLBF_PIN_CELLS{PLBF_OE_N_RST}};
        end
        else
        begin
            for (int j = 0; j < PLBF_PIN_CELLS; j++)
            begin
                pin_o_q[j] <= fb[2*j];
                unique case (plbf_oe_e'(CFG_OE[j]))
                    PLBF_OE_ON: pin_oe_n_q[j] <= 1'h0;
                    PLBF_OE_OFF: pin_oe_n_q[j] <= 1'h1; // Pin free as input
                    PLBF_OE_PT0: pin_oe_n_q[j] <= ~term[PLBF_PT_OE0];
                    PLBF_OE_PT1: pin_oe_n_q[j] <= ~term[PLBF_PT_OE1];
                    default: pin_oe_n_q[j] <= 1'h1;
                endcase
            end
        end
    end

    // =====================================================================
    // Outputs
    assign PIN_O = pin_o_q;
    assign PIN_OE_N = pin_oe_n_q;
    assign MC_FB = mc_fb_q;
    assign PIN_FB = pin_fb_q;
endmodule
`default_nettype wire

// >>> hdl/plbf_mcell.sv
// One macrocell: combinational, latched, D or T register, output inversion.
// Assumes the parent supplies a one-cycle clock edge and a sampled gate level.
`timescale 1ns/1ns
`default_nettype none
module plbf_mcell
    import plbf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sum,
    input wire logic pin_d,
    input wire logic inreg,
    input wire logic [2:0] mode,
    input wire logic ttype,
    input wire logic inv,
    input wire logic clk_rise,
    input wire logic gate_lvl,
    input wire logic clr,
    input wire logic set,
    output logic fb
);
    logic q_q;
    logic d;
    plbf_mode_e mode_e;

    // =====================================================================
    // Data selection
    assign mode_e = plbf_mode_e'(mode);
    assign d = inreg ? pin_d : sum; // Input register path

    // =====================================================================
    // Storage element
    // Clear beats set; both ignore the selected clock
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q_q <= PLBF_Q_RST;
        end
        else if (clr)
        begin
            q_q <= 1'h0;
        end
        else if (set)
        begin
            q_q <= 1'h1;
        end
        else
        begin
            unique case (mode_e)
                PLBF_MC_REG:
                begin
                    if (clk_rise && ttype && sum)
                    begin
                        q_q <= ~q_q;
                    end
                    else if (clk_rise && !ttype)
                    begin
                        q_q <= d;
                    end
                end
                PLBF_MC_LATCH:
                begin
                    if (!gate_lvl)
                    begin
                        q_q <= d; // Transparent while gate low
                    end
                end
                PLBF_MC_COMB:
                begin
                    q_q <= q_q;
                end
                default:
                begin
                    q_q <= q_q;
                end
            endcase
        end
    end

    // =====================================================================
    // Feedback in every mode, polarity applied
    always_comb
    begin
        if (mode_e == PLBF_MC_COMB)
        begin
            fb = d ^ inv;
        end
        else if (mode_e == PLBF_MC_LATCH && !gate_lvl && !clr && !set)
        begin
            fb = d ^ inv;
        end
        else
        begin
            fb = q_q ^ inv;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/plbf_pkg.sv
// Constants and encodings for one programmable logic block and its routing.
// Assumes a single system clock; all device pins are sampled into it.
package plbf_pkg;
    // =====================================================================
    // Block dimensions
    localparam int PLBF_TERMS = 64;
    localparam int PLBF_SPECIAL = 4;
    localparam int PLBF_ALL_TERMS = 68;
    localparam int PLBF_MCELLS = 16;
    localparam int PLBF_CLUSTERS = 16;
    localparam int PLBF_CL_SIZE = 4;
    localparam int PLBF_BLK_IN = 26;
    localparam int PLBF_PIN_CELLS = 8;
    localparam int PLBF_BLOCKS = 8;
    localparam int PLBF_IO_PINS = 64;
    localparam int PLBF_DED_IN = 2;
    localparam int PLBF_CLK_PINS = 4;
    // =====================================================================
    // Special product term positions
    localparam int PLBF_PT_OE0 = 64;
    localparam int PLBF_PT_OE1 = 65;
    localparam int PLBF_PT_CLR = 66;
    localparam int PLBF_PT_SET = 67;
    // =====================================================================
    // Routing source map
    localparam int PLBF_SRC_W = 8;
    localparam int PLBF_SRC_IO = 0;
    localparam int PLBF_SRC_DED = 64;
    localparam int PLBF_SRC_CLK = 66;
    localparam int PLBF_SRC_OWN = 70;
    localparam int PLBF_SRC_SIB = 86;
    localparam int PLBF_SRC_BLK = 94;
    localparam int PLBF_SRC_NUM = 158;
    // =====================================================================
    // Reset values
    localparam logic PLBF_Q_RST = 1'h0;
    localparam logic PLBF_OE_N_RST = 1'h1;
    // =====================================================================
    // Macrocell modes and pin driver modes
    typedef enum logic [2:0] {
        PLBF_MC_COMB = 3'h1,
        PLBF_MC_LATCH = 3'h2,
        PLBF_MC_REG = 3'h4
    } plbf_mode_e;
    typedef enum logic [3:0] {
        PLBF_OE_ON = 4'h1,
        PLBF_OE_OFF = 4'h2,
        PLBF_OE_PT0 = 4'h4,
        PLBF_OE_PT1 = 4'h8
    } plbf_oe_e;
endpackage

// >>> testbench/plbf_assertions.sv
// Checker for one logic block: reset, pin drivers, storage hold and clear.
// Assumes it is bound to plbf_block and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module plbf_assertions
    import plbf_pkg::*;
#(
    parameter int BLOCK_ID = 0
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [PLBF_IO_PINS-1:0] IO_PIN_I,
    input wire logic [PLBF_CLK_PINS-1:0] CLK_PIN,
    input wire logic [PLBF_ALL_TERMS-1:0][PLBF_BLK_IN-1:0] CFG_AND_T,
    input wire logic [PLBF_ALL_TERMS-1:0][PLBF_BLK_IN-1:0] CFG_AND_C,
    input wire logic [PLBF_MCELLS-1:0][2:0] CFG_MODE,
    input wire logic [PLBF_MCELLS-1:0] CFG_INV,
    input wire logic [PLBF_MCELLS-1:0][1:0] CFG_CLK_SEL,
    input wire logic [PLBF_PIN_CELLS-1:0][3:0] CFG_OE,
    input wire logic [PLBF_PIN_CELLS-1:0] PIN_O,
    input wire logic [PLBF_PIN_CELLS-1:0] PIN_OE_N,
    input wire logic [PLBF_MCELLS-1:0] MC_FB,
    input wire logic [PLBF_PIN_CELLS-1:0] PIN_FB
);
    // =====================================================================
    // Static term decoding
    logic clr_off;
    logic set_off;
    logic clr_on;
    logic [PLBF_MCELLS-1:0] store_mask;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // A literal in both senses never fires, an empty term always does
    assign clr_off = |(CFG_AND_T[PLBF_PT_CLR] & CFG_AND_C[PLBF_PT_CLR]);
    assign set_off = |(CFG_AND_T[PLBF_PT_SET] & CFG_AND_C[PLBF_PT_SET]);
    assign clr_on = (CFG_AND_T[PLBF_PT_CLR] == '0) && (CFG_AND_C[PLBF_PT_CLR] == '0);
    // =====================================================================
    // Sequences
    sequence calm_s;
        $stable(IO_PIN_I[BLOCK_ID*8 +: 8]) [*6];
    endsequence
    sequence hold_s(cond);
        (clr_off && set_off && cond) [*6];
    endsequence
    // =====================================================================
    // Whole-block properties
    chk_reset_outs: assert property (disable iff (1'b0) RST |=>
        PIN_O == '0 && PIN_OE_N == '1 && MC_FB == '0 && PIN_FB == '0) else $error("outputs not reset");
    chk_pin_fb_sync: assert property (calm_s |-> PIN_FB == IO_PIN_I[BLOCK_ID*8 +: 8])
        else $error("pin feedback wrong");
    chk_clr_forces: assert property ((clr_on) [*4] |-> (MC_FB & store_mask) == (CFG_INV & store_mask))
        else $error("clear term did not clear storage");
    // Per pin cell
    for (genvar j = 0; j < 8; j++)
    begin : g_pin
        chk_pin_mirror: assert property (PIN_O[j] == MC_FB[2*j]) else $error("pin differs from cell");
        chk_oe_on: assert property ((CFG_OE[j] == PLBF_OE_ON) [*3] |-> !PIN_OE_N[j])
            else $error("driver not on");
        chk_oe_off: assert property (!(CFG_OE[j] inside {PLBF_OE_ON, PLBF_OE_PT0, PLBF_OE_PT1}) [*3]
            |-> PIN_OE_N[j]) else $error("driver not off");
    end
    // Per macrocell
    for (genvar k = 0; k < 16; k++)
    begin : g_cell
        assign store_mask[k] = (CFG_MODE[k] != PLBF_MC_COMB);
        chk_reg_hold: assert property (hold_s(CFG_MODE[k] == PLBF_MC_REG && $stable(CLK_PIN))
            |-> $stable(MC_FB[k])) else $error("register changed without clock");
        chk_latch_hold: assert property (hold_s(CFG_MODE[k] == PLBF_MC_LATCH && CLK_PIN[CFG_CLK_SEL[k]])
            |-> $stable(MC_FB[k])) else $error("latch changed with gate high");
    end
endmodule
bind plbf_block plbf_assertions #(.BLOCK_ID(BLOCK_ID)) plbf_assertions_inst (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .IO_PIN_I(IO_PIN_I),
    .CLK_PIN(CLK_PIN),
    .CFG_AND_T(CFG_AND_T),
    .CFG_AND_C(CFG_AND_C),
    .CFG_MODE(CFG_MODE),
    .CFG_INV(CFG_INV),
    .CFG_CLK_SEL(CFG_CLK_SEL),
    .CFG_OE(CFG_OE),
    .PIN_O(PIN_O),
    .PIN_OE_N(PIN_OE_N),
    .MC_FB(MC_FB),
    .PIN_FB(PIN_FB)
);
`default_nettype wire

// >>> testbench/plbf_board.sv
// Board model: resolves the shared pins between block drivers and board sources.
// Assumes the board drives every pin wherever the block lets go of it.
`timescale 1ns/1ns
`default_nettype none
module plbf_board
#(
    parameter int BLOCK_ID = 0
)
(
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_n,
    input wire logic [63:0] ext,
    output logic [63:0] io_pin_i
);
    // Block wins where its driver is on, the board elsewhere
    always_comb
    begin
        io_pin_i = ext;
        for (int j = 0; j < 8; j++)
        begin
            if (!pin_oe_n[j])
            begin
                io_pin_i[BLOCK_ID*8+j] = pin_o[j];
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Testbench for one logic block with a board model on its pins.
// Assumes BLOCK_ID 0, so the block owns pins 0 to 7.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import plbf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [157:0] srcs = '0;
    logic [25:0][7:0] route;
    logic [67:0][25:0] and_t, and_c;
    logic [15:0] cl_en, ttype, inv;
    logic [15:0][1:0] cl_dest, clk_sel;
    logic [15:0][2:0] mode;
    logic [7:0] inreg, pin_o, pin_oe_n, pin_fb;
    logic [7:0][3:0] oe;
    logic [15:0] mc_fb;
    logic [63:0] io_pins;
    int error_cnt = 0;
    int n_compared = 0;
    int src_list[7] = '{8, 64, 65, 67, 89, 115, 157};
    int al_c[5] = '{2, 0, 3, 15, 15};
    logic [1:0] al_d[5] = '{2'h3, 2'h0, 2'h3, 2'h1, 2'h0};
    logic [15:0] al_e[5] = '{16'h0001, 16'h0002, 16'h0002, 16'h8000, 16'h0000};
    logic [3:0] oe_codes[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
    logic oe_exp[5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
    // =====================================================================
    // Clock, board and block
    always #5 sys_clk = ~sys_clk;
    plbf_board plbf_board_inst (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext(srcs[63:0]), .io_pin_i(io_pins));
    plbf_block plbf_block_inst (.SYS_CLK(sys_clk), .RST(rst), .IO_PIN_I(io_pins), .DED_IN(srcs[65:64]),
        .CLK_PIN(srcs[69:66]), .BLK_OUT_FB(srcs[157:94]), .SIB_BUR_FB(srcs[93:86]), .CFG_ROUTE(route),
        .CFG_AND_T(and_t), .CFG_AND_C(and_c), .CFG_CL_EN(cl_en), .CFG_CL_DEST(cl_dest), .CFG_MODE(mode),
        .CFG_TTYPE(ttype), .CFG_INV(inv), .CFG_CLK_SEL(clk_sel), .CFG_INREG(inreg), .CFG_OE(oe),
        .PIN_O(pin_o), .PIN_OE_N(pin_oe_n), .MC_FB(mc_fb), .PIN_FB(pin_fb));
    // =====================================================================
    // Access tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic drv(input int i, input logic v);
        @(negedge sys_clk);
        srcs[i] = v;
        cyc(6);
    endtask
    task automatic pulse(input int s);
        drv(66 + s, 1'b1);
        drv(66 + s, 1'b0);
    endtask
    task automatic restart(input int n);
        @(negedge sys_clk);
        rst = 1'b1;
        cyc(n);
        rst = 1'b0;
    endtask
    // Idle setup: terms never fire, all cells combinational, drivers off
    task automatic base();
        srcs = '0;
        route = '1;
        route[0] = 8'h40;
        for (int t = 0; t < 68; t++)
        begin
            and_t[t] = 26'h2;
            and_c[t] = 26'h2;
        end
        {cl_en, ttype, inv, inreg} = '0;
        cl_dest = '0;
        clk_sel = '0;
        mode = {16{PLBF_MC_COMB}};
        oe = {8{PLBF_OE_OFF}};
    endtask
    task automatic use_cl(input int c, input logic [1:0] d);
        and_t[4*c] = 26'h1;
        and_c[4*c] = '0;
        cl_en[c] = 1'b1;
        cl_dest[c] = d;
    endtask
    task automatic report_and_stop();
        $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // =====================================================================
    // Watchdog
    initial
    begin
        cyc(20000);
        error_cnt++;
        report_and_stop();
    end
    // Test sequence
    initial
    begin
        base();
        cyc(16);
        chk({pin_o, pin_oe_n}, 16'h00FF);
        chk(mc_fb, 16'h0000);
        rst = 1'b0;
        $display("reset test done");
        use_cl(0, 2'h1);
        oe[0] = PLBF_OE_ON;
        foreach (src_list[i])
        begin
            route[0] = 8'(src_list[i]);
            restart(3);
            drv(src_list[i], 1'b1);
            chk({mc_fb[0], pin_o[0], pin_oe_n[0]}, 16'h0006);
            drv(src_list[i], 1'b0);
            chk({mc_fb[0], pin_o[0]}, 16'h0000);
        end
        $display("routing test done");
        foreach (al_c[i])
        begin
            base();
            use_cl(al_c[i], al_d[i]);
            restart(3);
            drv(64, 1'b1);
            chk(mc_fb, al_e[i]);
        end
        $display("allocation test done");
        base();
        use_cl(0, 2'h1);
        mode[0] = PLBF_MC_REG;
        clk_sel[0] = 2'h2;
        oe[0] = PLBF_OE_ON;
        restart(3);
        drv(64, 1'b1);
        pulse(1);
        chk(mc_fb[0], 16'h0000);
        pulse(2);
        chk({mc_fb[0], pin_o[0]}, 16'h0003);
        drv(64, 1'b0);
        pulse(2);
        chk(mc_fb[0], 16'h0000);
        ttype[0] = 1'b1;
        inv[0] = 1'b1;
        restart(3);
        cyc(2);
        chk(mc_fb[0], 16'h0001);
        drv(64, 1'b1);
        pulse(2);
        chk(mc_fb[0], 16'h0000);
        pulse(2);
        chk(mc_fb[0], 16'h0001);
        drv(64, 1'b0);
        pulse(2);
        chk(mc_fb[0], 16'h0001);
        $display("register test done");
        base();
        use_cl(0, 2'h1);
        mode[0] = PLBF_MC_LATCH;
        clk_sel[0] = 2'h3;
        restart(3);
        drv(64, 1'b1);
        chk(mc_fb[0], 16'h0001);
        drv(69, 1'b1);
        drv(64, 1'b0);
        chk(mc_fb[0], 16'h0001);
        drv(69, 1'b0);
        chk(mc_fb[0], 16'h0000);
        $display("latch test done");
        base();
        mode = {16{PLBF_MC_REG}};
        route[1] = 8'h41;
        route[2] = 8'h45;
        and_c[PLBF_PT_SET] = '0;
        and_t[PLBF_PT_CLR] = 26'h4;
        and_c[PLBF_PT_CLR] = '0;
        restart(3);
        drv(65, 1'b1);
        chk(mc_fb, 16'hFFFF);
        drv(69, 1'b1);
        chk(mc_fb, 16'h0000);
        and_t[PLBF_PT_CLR] = '0;
        inv[3] = 1'b1;
        restart(3);
        cyc(6);
        chk(mc_fb, 16'h0008);
        $display("clear and set test done");
        base();
        and_t[PLBF_PT_OE0] = 26'h1;
        and_c[PLBF_PT_OE0] = '0;
        and_t[PLBF_PT_OE1] = '0;
        and_c[PLBF_PT_OE1] = 26'h1;
        foreach (oe_codes[i])
        begin
            oe[0] = oe_codes[i];
            restart(3);
            drv(64, 1'b1);
            chk(pin_oe_n[0], oe_exp[i]);
        end
        $display("driver test done");
        base();
        inreg[0] = 1'b1;
        mode[1] = PLBF_MC_REG;
        restart(3);
        drv(0, 1'b1);
        chk(pin_fb[0], 16'h0001);
        pulse(0);
        chk(mc_fb[1], 16'h0001);
        drv(0, 1'b0);
        chk(mc_fb[1], 16'h0001);
        $display("pin input test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
